// File: dca_pkg.sv
// shared constants and types for the dual channel allegiance arbiter
package dca_pkg;

  typedef enum logic [2:0] {
    DCA_NEUTRAL    = 3'b000,
    DCA_SHORT      = 3'b001,
    DCA_PRESENT    = 3'b010,
    DCA_IMPLICIT   = 3'b011,
    DCA_CONTINGENT = 3'b100
  } dca_state_e;

  typedef enum logic [1:0] {
    DCA_K_NONE  = 2'b00,
    DCA_K_UNTAG = 2'b01,
    DCA_K_ISEL  = 2'b10,
    DCA_K_DE    = 2'b11
  } dca_kind_e;

  // status bytes
  localparam logic [7:0] ST_ZERO     = 8'h00;
  localparam logic [7:0] ST_UNIT_CHK = 8'h02;
  localparam logic [7:0] ST_DEV_END  = 8'h04;
  localparam logic [7:0] ST_CE_DE    = 8'h0C;
  localparam logic [7:0] ST_DEV_BUSY = 8'h10;
  localparam logic [7:0] ST_CU_BUSY  = 8'h70;

  // command bytes
  localparam logic [7:0] CMD_TIO  = 8'h00;
  localparam logic [7:0] CMD_NOOP = 8'h03;

  // pin bundle layout, two bits (A, B) per signal
  localparam int PIN_W   = 14;
  localparam int P_SEL   = 0;
  localparam int P_ADDR  = 2;
  localparam int P_SYSR  = 4;
  localparam int P_SELR  = 6;
  localparam int P_ACC   = 8;
  localparam int P_STACK = 10;
  localparam int P_PANEL = 12;

  // reset values
  localparam logic [1:0] RST_PAIR = 2'b00;
  localparam logic [7:0] RST_BYTE = 8'h00;

endpackage : dca_pkg

// File: dca_pin_if.sv
// channel pin bundle passed between the synchroniser and the arbiter
interface dca_pin_if;
  logic [dca_pkg::PIN_W-1:0] raw;
  logic [dca_pkg::PIN_W-1:0] synced;

  modport syncer (input raw, output synced);
  modport user   (output raw, input synced);
endinterface : dca_pin_if

// File: dca_sync.sv
// two flip-flop synchroniser for the channel pin bundle
module dca_sync (
  input wire logic mclk,
  input wire logic rst_b,
  dca_pin_if.syncer pins
);

  logic [dca_pkg::PIN_W-1:0] meta_r;
  logic [dca_pkg::PIN_W-1:0] sync_r;

  // meta_r feeds sync_r only; nothing else may look at it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pins.raw;
      sync_r <= meta_r;
    end
  end

  assign pins.synced = sync_r;

endmodule : dca_sync

// File: dca_arbiter.sv
// allegiance arbiter binding the channel adapter to channel interface A or B
module dca_arbiter (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  sel_out,
  input  wire logic [1:0]  addr_match,
  input  wire logic [1:0]  sys_reset_in,
  input  wire logic [1:0]  selective_reset_in,
  input  wire logic [1:0]  chan_accept,
  input  wire logic [1:0]  chan_stack,
  input  wire logic [1:0]  panel_on,
  input  wire logic [1:0]  if_enable,
  input  wire logic        async_start,
  input  wire logic [7:0]  async_status,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        cmd_chain,
  input  wire logic        end_valid,
  input  wire logic [7:0]  end_status,
  input  wire logic        end_chain,
  input  wire logic        if_disconnect,
  input  wire logic        sw_reset_neutral,
  input  wire logic        sw_present_de,
  input  wire logic        sw_cmd_decoded,
  input  wire logic        allow_disable,
  input  wire logic        prog_int_pend,
  input  wire logic        isel_int_clr,
  input  wire logic        ds_int_clr,
  output logic [1:0]       req_in,
  output logic [1:0]       sel_bypass,
  output logic [1:0]       connect,
  output logic [1:0]       status_in,
  output logic [15:0]      status_byte,
  output logic             isel_int,
  output logic             ds_int,
  output logic [2:0]       allegiance,
  output logic             adapter_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  dca_pin_if pins ();

  assign pins.raw = {panel_on, chan_stack, chan_accept, selective_reset_in,
                     sys_reset_in, addr_match, sel_out};

  dca_sync u_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pins  (pins)
  );

  function automatic logic [1:0] pair(input logic [dca_pkg::PIN_W-1:0] v, input int pos);
    pair = v[pos +: 2];
  endfunction : pair

  function automatic logic [1:0] rise(input logic [1:0] now, input logic [1:0] was);
    rise = now & ~was;
  endfunction : rise

  logic [dca_pkg::PIN_W-1:0] prev_r;

  wire [1:0] sel_s   = pair(pins.synced, dca_pkg::P_SEL);
  wire [1:0] addr_s  = pair(pins.synced, dca_pkg::P_ADDR);
  wire [1:0] panel_s = pair(pins.synced, dca_pkg::P_PANEL);
  wire [1:0] sel_ev  = rise(sel_s, pair(prev_r, dca_pkg::P_SEL));
  wire [1:0] sysr_ev = rise(pair(pins.synced, dca_pkg::P_SYSR), pair(prev_r, dca_pkg::P_SYSR));
  wire [1:0] selr_ev = rise(pair(pins.synced, dca_pkg::P_SELR), pair(prev_r, dca_pkg::P_SELR));
  wire [1:0] acc_ev  = rise(pair(pins.synced, dca_pkg::P_ACC), pair(prev_r, dca_pkg::P_ACC));
  wire [1:0] stk_ev  = rise(pair(pins.synced, dca_pkg::P_STACK), pair(prev_r, dca_pkg::P_STACK));
  wire [1:0] pnl_off = pair(prev_r, dca_pkg::P_PANEL) & ~panel_s;
  wire [1:0] done_ev = acc_ev | stk_ev;

  ////////////////////////////////////////////////////////////////////////////
  // state

  dca_pkg::dca_state_e state_r, state_nxt;
  dca_pkg::dca_kind_e  kind_r, kind_nxt;
  dca_pkg::dca_state_e after_r, after_nxt;
  logic                owner_r, owner_nxt;
  logic [7:0]          pres_r, pres_nxt;
  logic                sel_untag_r, sel_untag_nxt;
  logic [1:0]          held_r, held_nxt;
  logic [1:0]          busy_r, busy_nxt;
  logic [1:0]          de_owed_r, de_owed_nxt;
  logic                untag_r, untag_nxt;
  logic [7:0]          async_r, async_nxt;
  logic                ending_r, ending_nxt;
  logic [7:0]          end_r, end_nxt;
  logic                end_chain_r, end_chain_nxt;
  logic                disc_r, disc_nxt;
  logic                dis_req_r, dis_req_nxt;
  logic                isel_r, isel_nxt;
  logic                ds_r, ds_nxt;
  logic                areset_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire [1:0] en        = if_enable & panel_s;
  wire       neutral   = (state_r == dca_pkg::DCA_NEUTRAL);
  wire       long_term = (state_r == dca_pkg::DCA_IMPLICIT) ||
                         (state_r == dca_pkg::DCA_CONTINGENT);
  wire [1:0] owner_oh  = owner_r ? 2'b10 : 2'b01;
  wire [1:0] de_go     = de_owed_r & {2{~isel_r & ~ds_r & ~prog_int_pend}};
  wire       untag_go  = untag_r & ~isel_r & ~ds_r & ~(|de_go);
  // polls only ours while we request; everything else on a blocked side is passed on
  assign req_in     = {2{neutral}} & en & (de_go | {2{untag_go}});
  wire [1:0] ours   = req_in | addr_s;
  assign sel_bypass = sel_s & (~en | ~ours);
  wire [1:0] new_ev = (sel_ev | held_r) & en & ours;
  wire       pick   = ~new_ev[0];
  wire [1:0] pick_oh = pick ? 2'b10 : 2'b01;
  wire       is_tio  = (cmd_byte == dca_pkg::CMD_TIO);
  wire       is_noop = (cmd_byte == dca_pkg::CMD_NOOP);
  wire       full_both = &sysr_ev;
  wire       full_own  = !neutral && sysr_ev[owner_r];
  wire       final_de  = end_r[2] && !end_chain_r;

  assign connect     = {2{!neutral}} & owner_oh;
  assign status_in   = busy_r | ({2{(state_r == dca_pkg::DCA_PRESENT) ||
                                    (state_r == dca_pkg::DCA_IMPLICIT && ending_r)}} & owner_oh);
  assign allegiance  = state_r;
  assign isel_int    = isel_r;
  assign ds_int      = ds_r;

  logic [15:0] stat_r, stat_nxt;
  logic        areset_r;
  assign status_byte   = stat_r;
  assign adapter_reset = areset_r;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_nxt     = state_r;
    kind_nxt      = kind_r;
    after_nxt     = after_r;
    owner_nxt     = owner_r;
    pres_nxt      = pres_r;
    sel_untag_nxt = sel_untag_r;
    held_nxt      = held_r;
    busy_nxt      = busy_r;
    de_owed_nxt   = de_owed_r;
    untag_nxt     = untag_r;
    async_nxt     = async_r;
    ending_nxt    = ending_r;
    end_nxt       = end_r;
    end_chain_nxt = end_chain_r;
    disc_nxt      = disc_r;
    dis_req_nxt   = dis_req_r;
    isel_nxt      = isel_r & ~isel_int_clr;
    ds_nxt        = ds_r & ~ds_int_clr;
    stat_nxt      = stat_r;
    areset_nxt    = 1'b0;

    if (async_start) begin
      untag_nxt = 1'b1;
      async_nxt = async_status;
    end
    if (allow_disable || (long_term && |(pnl_off & owner_oh)))
      dis_req_nxt = 1'b1;
    if (end_valid) begin
      ending_nxt    = 1'b1;
      end_nxt       = end_status;
      end_chain_nxt = end_chain;
      stat_nxt[owner_r*8 +: 8] = end_status;
    end
    if (if_disconnect)
      disc_nxt = 1'b1;

    for (int s = 0; s < 2; s++) begin
      if (busy_r[s] && done_ev[s]) begin
        busy_nxt[s] = 1'b0;
        if (!dis_req_r)
          de_owed_nxt[s] = 1'b1;
      end
    end

    case (state_r)
      dca_pkg::DCA_NEUTRAL: begin
        if (|new_ev) begin
          held_nxt[pick] = 1'b0;
          held_nxt[~pick] = held_r[~pick] | sel_ev[~pick];
          owner_nxt = pick;
          after_nxt = dca_pkg::DCA_NEUTRAL;
          if (isel_r) begin
            state_nxt = dca_pkg::DCA_PRESENT;
            kind_nxt  = dca_pkg::DCA_K_NONE;
            pres_nxt  = dca_pkg::ST_CU_BUSY;
          end else if (req_in[pick] && de_go[pick]) begin
            state_nxt = dca_pkg::DCA_PRESENT;
            kind_nxt  = dca_pkg::DCA_K_DE;
            pres_nxt  = dca_pkg::ST_DEV_END | (untag_r ? async_r : dca_pkg::RST_BYTE);
          end else if (req_in[pick]) begin
            state_nxt = dca_pkg::DCA_PRESENT;
            kind_nxt  = dca_pkg::DCA_K_UNTAG;
            pres_nxt  = async_r;
          end else begin
            state_nxt     = dca_pkg::DCA_SHORT;
            sel_untag_nxt = untag_r;
          end
          stat_nxt[pick*8 +: 8] = pres_nxt;
        end
      end
      dca_pkg::DCA_SHORT: begin
        if (cmd_valid) begin
          state_nxt = dca_pkg::DCA_PRESENT;
          kind_nxt  = dca_pkg::DCA_K_NONE;
          after_nxt = dca_pkg::DCA_NEUTRAL;
          if (sel_untag_r) begin
            kind_nxt = dca_pkg::DCA_K_ISEL;
            pres_nxt = async_r | (is_tio ? dca_pkg::RST_BYTE : dca_pkg::ST_DEV_BUSY);
          end else if (is_noop && !cmd_chain) begin
            pres_nxt = dca_pkg::ST_CE_DE;
          end else if (is_tio) begin
            pres_nxt = dca_pkg::ST_ZERO;
          end else begin
            pres_nxt  = dca_pkg::ST_ZERO;
            after_nxt = dca_pkg::DCA_IMPLICIT;
          end
          stat_nxt[owner_r*8 +: 8] = pres_nxt;
        end
      end
      dca_pkg::DCA_PRESENT: begin
        if (done_ev[owner_r]) begin
          state_nxt  = after_r;
          disc_nxt   = 1'b0;
          ending_nxt = 1'b0;
          case (kind_r)
            dca_pkg::DCA_K_UNTAG: begin
              ds_nxt    = 1'b1;
              untag_nxt = 1'b0;
            end
            dca_pkg::DCA_K_ISEL: begin
              isel_nxt  = 1'b1;
              untag_nxt = 1'b0;
            end
            dca_pkg::DCA_K_DE: begin
              de_owed_nxt[owner_r] = 1'b0;
              untag_nxt = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      dca_pkg::DCA_IMPLICIT: begin
        if (ending_r && done_ev[owner_r]) begin
          ending_nxt = 1'b0;
          if (final_de)
            state_nxt = (end_r & dca_pkg::ST_UNIT_CHK) != dca_pkg::RST_BYTE ?
                        dca_pkg::DCA_CONTINGENT : dca_pkg::DCA_NEUTRAL;
        end
        if (disc_r && (sw_reset_neutral || sw_present_de))
          state_nxt = dca_pkg::DCA_NEUTRAL;
      end
      dca_pkg::DCA_CONTINGENT: begin
        if (sw_cmd_decoded)
          state_nxt = dca_pkg::DCA_NEUTRAL;
      end
      default: state_nxt = dca_pkg::DCA_NEUTRAL;
    endcase

    // opposite side while the adapter belongs to the owner
    if (!neutral && ((sel_ev[~owner_r] && en[~owner_r] && addr_s[~owner_r]) ||
                     held_r[~owner_r])) begin
      if (long_term && !busy_r[~owner_r]) begin
        busy_nxt[~owner_r] = 1'b1;
        held_nxt[~owner_r] = 1'b0;
        stat_nxt[(owner_r ? 0 : 8) +: 8] = dca_pkg::ST_DEV_BUSY;
      end else if (!long_term) begin
        held_nxt[~owner_r] = 1'b1;
      end
    end

    if (!neutral && state_nxt == dca_pkg::DCA_NEUTRAL && long_term && dis_req_r) begin
      de_owed_nxt = dca_pkg::RST_PAIR;
      dis_req_nxt = 1'b0;
    end

    // channel resets take precedence over everything above
    if (full_both || full_own) begin
      state_nxt     = dca_pkg::DCA_NEUTRAL;
      kind_nxt      = dca_pkg::DCA_K_NONE;
      after_nxt     = dca_pkg::DCA_NEUTRAL;
      sel_untag_nxt = 1'b0;
      held_nxt      = dca_pkg::RST_PAIR;
      busy_nxt      = dca_pkg::RST_PAIR;
      untag_nxt     = 1'b0;
      ending_nxt    = 1'b0;
      disc_nxt      = 1'b0;
      dis_req_nxt   = 1'b0;
      ds_nxt        = 1'b0;
      isel_nxt      = 1'b1;
      areset_nxt    = 1'b1;
      de_owed_nxt   = full_both ? dca_pkg::RST_PAIR : (de_owed_r & ~owner_oh);
    end else begin
      de_owed_nxt = de_owed_nxt & ~sysr_ev;
      if (!neutral && selr_ev[owner_r]) begin
        state_nxt  = dca_pkg::DCA_NEUTRAL;
        isel_nxt   = 1'b1;
        ending_nxt = 1'b0;
        de_owed_nxt[owner_r] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= dca_pkg::DCA_NEUTRAL;
      kind_r      <= dca_pkg::DCA_K_NONE;
      after_r     <= dca_pkg::DCA_NEUTRAL;
      owner_r     <= 1'b0;
      pres_r      <= dca_pkg::RST_BYTE;
      sel_untag_r <= 1'b0;
      held_r      <= dca_pkg::RST_PAIR;
      busy_r      <= dca_pkg::RST_PAIR;
      de_owed_r   <= dca_pkg::RST_PAIR;
      untag_r     <= 1'b0;
      async_r     <= dca_pkg::RST_BYTE;
      ending_r    <= 1'b0;
      end_r       <= dca_pkg::RST_BYTE;
      end_chain_r <= 1'b0;
      disc_r      <= 1'b0;
      dis_req_r   <= 1'b0;
      isel_r      <= 1'b0;
      ds_r        <= 1'b0;
      stat_r      <= '0;
      areset_r    <= 1'b0;
      prev_r      <= '0;
    end else begin
      state_r     <= state_nxt;
      kind_r      <= kind_nxt;
      after_r     <= after_nxt;
      owner_r     <= owner_nxt;
      pres_r      <= pres_nxt;
      sel_untag_r <= sel_untag_nxt;
      held_r      <= held_nxt;
      busy_r      <= busy_nxt;
      de_owed_r   <= de_owed_nxt;
      untag_r     <= untag_nxt;
      async_r     <= async_nxt;
      ending_r    <= ending_nxt;
      end_r       <= end_nxt;
      end_chain_r <= end_chain_nxt;
      disc_r      <= disc_nxt;
      dis_req_r   <= dis_req_nxt;
      isel_r      <= isel_nxt;
      ds_r        <= ds_nxt;
      stat_r      <= stat_nxt;
      areset_r    <= areset_nxt;
      prev_r      <= pins.synced;
    end
  end

endmodule : dca_arbiter

// File: dca_arbiter_chk.sv
// concurrent checks on the allegiance arbiter ports
module dca_arbiter_chk (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [1:0]  sel_out,
  input wire logic [1:0]  addr_match,
  input wire logic [1:0]  sys_reset_in,
  input wire logic [1:0]  chan_accept,
  input wire logic [1:0]  panel_on,
  input wire logic [1:0]  if_enable,
  input wire logic        async_start,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_byte,
  input wire logic [1:0]  req_in,
  input wire logic [1:0]  sel_bypass,
  input wire logic [1:0]  connect,
  input wire logic [1:0]  status_in,
  input wire logic [15:0] status_byte,
  input wire logic        isel_int,
  input wire logic        ds_int,
  input wire logic [2:0]  allegiance,
  input wire logic        adapter_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // last command byte: test i/o and unchained no-op give no long-term allegiance
  logic [7:0] cmd_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) cmd_r <= dca_pkg::RST_BYTE;
    else if (cmd_valid) cmd_r <= cmd_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin steps allow for the two-flop synchroniser delay
  sequence s_sel_b;
    !sel_out[1] ##1 (sel_out[1] && addr_match[1])[*2];
  endsequence
  sequence s_acc_a;
    !chan_accept[0] ##1 chan_accept[0][*3];
  endsequence
  sequence s_sys(logic [1:0] m);
    sys_reset_in == 2'h0 ##1 (sys_reset_in == m)[*3];
  endsequence

  a_one_owner: assert property (connect != 2'h3 &&
    (allegiance == dca_pkg::DCA_NEUTRAL || connect != 2'h0)) else $error("owner wrong");
  a_disabled_bypass: assert property ((sel_out[0] && !(if_enable[0] && panel_on[0]))[*4]
    |-> sel_bypass[0]) else $error("disabled side select out not passed on");
  a_untagged_req: assert property (async_start && allegiance == dca_pkg::DCA_NEUTRAL &&
    !isel_int && !ds_int && if_enable == 2'h3 && panel_on == 2'h3
    |-> ##[1:3] req_in == 2'h3) else $error("untagged status not offered to both");
  a_implicit_entry: assert property ((status_in == 2'h1 && status_byte[7:0] == 8'h00 &&
    allegiance == dca_pkg::DCA_PRESENT && cmd_r != dca_pkg::CMD_TIO &&
    cmd_r != dca_pkg::CMD_NOOP) ##0 s_acc_a |-> ##[1:3] allegiance == dca_pkg::DCA_IMPLICIT)
    else $error("no implicit allegiance after zero status");
  a_busy_opposite: assert property ((connect == 2'h1 && (allegiance == 3'h3 ||
    allegiance == 3'h4)) ##0 s_sel_b |-> ##[1:4]
    (status_in[1] && status_byte[15:8] == dca_pkg::ST_DEV_BUSY)) else $error("no busy reply");
  a_cu_busy: assert property ((isel_int && !req_in[1] && allegiance == 3'h0) ##0 s_sel_b
    |-> ##[1:4] (status_in[1] && status_byte[15:8] == dca_pkg::ST_CU_BUSY))
    else $error("no control unit busy reply");
  a_owner_sysreset: assert property ((allegiance != 3'h0 && connect == 2'h1) ##0
    s_sys(2'h1) |-> ##[1:3] (isel_int && allegiance == dca_pkg::DCA_NEUTRAL))
    else $error("owner system reset not handled");
  a_neutral_sysreset: assert property ((allegiance == 3'h0 && !isel_int) ##0
    s_sys(2'h1) |=> (!isel_int && !adapter_reset)[*4]) else $error("neutral reset too wide");
  a_both_sysreset: assert property (s_sys(2'h3) |-> ##[1:3] adapter_reset ##[0:2]
    isel_int) else $error("dual system reset not handled");
endmodule : dca_arbiter_chk

bind dca_arbiter dca_arbiter_chk chk_i (.*);

// File: dca_host_model.sv
// behavioural model of the two host channels
module dca_host_model (
  input  wire logic       mclk,
  input  wire logic [1:0] req_in,
  output logic [1:0]      sel_out,
  output logic [1:0]      addr_match,
  output logic [1:0]      sys_reset_in,
  output logic [1:0]      chan_accept
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {sel_out, addr_match, sys_reset_in, chan_accept} = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // tags are driven just after a falling edge, never on the sampling edge
  task automatic select(input int s);
    addr_match[s] = 1'b1;
    sel_out[s] = 1'b1;
  endtask : select

  // a poll waits a bounded time for request in, then answers regardless
  task automatic poll(input int s);
    for (int i = 0; i < 20 && !req_in[s]; i++) @(negedge mclk);
    sel_out[s] = 1'b1;
  endtask : poll

  // accept drops every tag of that side so the next rise is a fresh edge
  task automatic accept(input int s);
    chan_accept[s] = 1'b1;
    repeat (4) @(negedge mclk);
    {chan_accept[s], sel_out[s], addr_match[s]} = 3'h0;
    repeat (4) @(negedge mclk);
  endtask : accept

  task automatic sysrst(input logic [1:0] m);
    sys_reset_in = m;
    repeat (4) @(negedge mclk);
    sys_reset_in = 2'h0;
    repeat (4) @(negedge mclk);
  endtask : sysrst
endmodule : dca_host_model

// File: dual_channel_allegiance_arbiter_tb_top.sv
// self-checking bench for the allegiance arbiter
module dual_channel_allegiance_arbiter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_b, async_start, cmd_valid, cmd_chain, end_valid, end_chain;
  logic        if_disconnect, sw_reset_neutral, sw_present_de, sw_cmd_decoded;
  logic        allow_disable, prog_int_pend, isel_int_clr, ds_int_clr;
  logic        isel_int, ds_int, adapter_reset;
  logic [1:0]  sel_out, addr_match, sys_reset_in, selective_reset_in, chan_accept;
  logic [1:0]  chan_stack, panel_on, if_enable, req_in, sel_bypass, connect, status_in;
  logic [7:0]  async_status, cmd_byte, end_status;
  logic [15:0] status_byte;
  logic [2:0]  allegiance;
  int          err_total, n_tests;

  dca_arbiter    uut (.*);
  dca_host_model hm  (.*);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: exp %h got %h", $time, exp, got);
    end
  endtask : chk

  task automatic waitst(input logic [2:0] st);
    int i;
    for (i = 0; i < 40 && allegiance !== st; i++) @(negedge mclk);
    chk(st, allegiance);
    if (i == 40) complete_run();
  endtask : waitst

  task automatic cmd(input logic [7:0] b, input logic c);
    {cmd_byte, cmd_chain, cmd_valid} = {b, c, 1'b1};
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask : cmd

  task automatic fin(input logic [7:0] s);
    {end_status, end_valid} = {s, 1'b1};
    @(negedge mclk);
    end_valid = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : fin

  // poll a side that was offered status, check the byte, accept it
  task automatic drain(input int s, input logic [7:0] b);
    hm.poll(s);
    chk(1'b1, req_in[s]);
    if (!req_in[s]) complete_run();
    repeat (4) @(negedge mclk);
    chk(b, status_byte[8*s +: 8]);
    chk(16'h1 << s, status_in);
    hm.accept(s);
  endtask : drain

  task automatic go_impl(input logic [7:0] b, input logic c);
    hm.select(0);
    waitst(dca_pkg::DCA_SHORT);
    chk(2'h1, connect);
    cmd(b, c);
    waitst(dca_pkg::DCA_PRESENT);
    chk(dca_pkg::ST_ZERO, status_byte[7:0]);
    hm.accept(0);
    chk(dca_pkg::DCA_IMPLICIT, allegiance);
  endtask : go_impl

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_disabled();
    {if_enable, panel_on} = 4'h9;
    hm.select(0);
    hm.select(1);
    repeat (5) @(negedge mclk);
    chk(2'h3, sel_bypass);
    chk(2'h0, connect);
    hm.accept(0);
    hm.accept(1);
    {if_enable, panel_on} = 4'hF;
  endtask : t_disabled

  task automatic t_busy_release();
    go_impl(dca_pkg::CMD_NOOP, 1'b1);
    hm.select(1);
    repeat (5) @(negedge mclk);
    chk(dca_pkg::ST_DEV_BUSY, status_byte[15:8]);
    hm.accept(1);
    chk(2'h1, connect);
    prog_int_pend = 1'b1;
    fin(dca_pkg::ST_CE_DE);
    hm.accept(0);
    chk(dca_pkg::DCA_NEUTRAL, allegiance);
    chk(2'h0, req_in);
    prog_int_pend = 1'b0;
    drain(1, dca_pkg::ST_DEV_END);
  endtask : t_busy_release

  task automatic t_contingent();
    go_impl(8'h02, 1'b0);
    fin(dca_pkg::ST_UNIT_CHK | dca_pkg::ST_CE_DE);
    hm.accept(0);
    chk(dca_pkg::DCA_CONTINGENT, allegiance);
    hm.select(1);
    repeat (5) @(negedge mclk);
    chk(dca_pkg::ST_DEV_BUSY, status_byte[15:8]);
    hm.accept(1);
    sw_cmd_decoded = 1'b1;
    @(negedge mclk);
    sw_cmd_decoded = 1'b0;
    waitst(dca_pkg::DCA_NEUTRAL);
    drain(1, dca_pkg::ST_DEV_END);
  endtask : t_contingent

  // both ways out of a disconnected operation
  task automatic t_disconnect();
    for (int k = 0; k < 2; k++) begin
      go_impl(8'h01, 1'b0);
      if_disconnect = 1'b1;
      @(negedge mclk);
      if_disconnect = 1'b0;
      repeat (8) @(negedge mclk);
      chk(dca_pkg::DCA_IMPLICIT, allegiance);
      {sw_reset_neutral, sw_present_de} = (k == 0) ? 2'h2 : 2'h1;
      @(negedge mclk);
      {sw_reset_neutral, sw_present_de} = 2'h0;
      waitst(dca_pkg::DCA_NEUTRAL);
      chk(2'h0, req_in);
    end
  endtask : t_disconnect

  task automatic t_untagged();
    {async_status, async_start} = {8'h01, 1'b1};
    @(negedge mclk);
    async_start = 1'b0;
    repeat (2) @(negedge mclk);
    chk(2'h3, req_in);
    drain(1, 8'h01);
    chk(1'b1, ds_int);
    chk(dca_pkg::DCA_NEUTRAL, allegiance);
    ds_int_clr = 1'b1;
    @(negedge mclk);
    ds_int_clr = 1'b0;
  endtask : t_untagged

  // chained ending keeps allegiance; a requested disable drops the owed device end
  task automatic t_chain_disable();
    go_impl(dca_pkg::CMD_NOOP, 1'b1);
    hm.select(1);
    repeat (5) @(negedge mclk);
    hm.accept(1);
    end_chain = 1'b1;
    fin(dca_pkg::ST_CE_DE);
    hm.accept(0);
    chk(dca_pkg::DCA_IMPLICIT, allegiance);
    {end_chain, allow_disable} = 2'h1;
    @(negedge mclk);
    allow_disable = 1'b0;
    fin(dca_pkg::ST_CE_DE);
    hm.accept(0);
    chk(dca_pkg::DCA_NEUTRAL, allegiance);
    chk(2'h0, req_in);
  endtask : t_chain_disable

  task automatic t_stack_selr();
    {async_status, async_start} = {8'h02, 1'b1};
    @(negedge mclk);
    async_start = 1'b0;
    hm.poll(0);
    chk(1'b1, req_in[0]);
    if (!req_in[0]) complete_run();
    repeat (4) @(negedge mclk);
    chk(8'h02, status_byte[7:0]);
    chan_stack[0] = 1'b1;
    repeat (4) @(negedge mclk);
    chk(1'b1, ds_int);
    chan_stack[0] = 1'b0;
    hm.accept(0);
    ds_int_clr = 1'b1;
    @(negedge mclk);
    ds_int_clr = 1'b0;
    go_impl(8'h01, 1'b0);
    selective_reset_in[0] = 1'b1;
    repeat (4) @(negedge mclk);
    chk(dca_pkg::DCA_NEUTRAL, allegiance);
    chk(1'b1, isel_int);
    {selective_reset_in[0], isel_int_clr} = 2'h1;
    @(negedge mclk);
    isel_int_clr = 1'b0;
  endtask : t_stack_selr

  task automatic t_owner_reset();
    go_impl(8'h02, 1'b0);
    hm.sysrst(2'h1);
    chk(1'b1, isel_int);
    chk(dca_pkg::DCA_NEUTRAL, allegiance);
    hm.select(1);
    repeat (5) @(negedge mclk);
    chk(dca_pkg::ST_CU_BUSY, status_byte[15:8]);
    hm.accept(1);
    isel_int_clr = 1'b1;
    @(negedge mclk);
    isel_int_clr = 1'b0;
  endtask : t_owner_reset

  task automatic t_neutral_resets();
    hm.sysrst(2'h1);
    chk(1'b0, isel_int);
    hm.sysrst(2'h3);
    chk(1'b1, isel_int);
  endtask : t_neutral_resets

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {err_total, n_tests} = {32'h0, 32'h0};
    {rst_b, panel_on, if_enable, selective_reset_in, chan_stack} = 9'h0F0;
    {async_status, cmd_byte, end_status} = 24'h000000;
    {async_start, cmd_valid, cmd_chain, end_valid, end_chain, if_disconnect} = 6'h00;
    {sw_reset_neutral, sw_present_de, sw_cmd_decoded, allow_disable} = 4'h0;
    {prog_int_pend, isel_int_clr, ds_int_clr} = 3'h0;
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    t_disabled();
    t_busy_release();
    t_contingent();
    t_disconnect();
    t_untagged();
    t_chain_disable();
    t_stack_selr();
    t_owner_reset();
    t_neutral_resets();
    complete_run();
  end
endmodule : dual_channel_allegiance_arbiter_tb_top
